// ===== verilog/ffo_device.sv
`timescale 1ns/100ps
// Summary of operation
// [RULE1] empty: ir low, paf high, hf high, pae low, or high
// [RULE2] pae high from n+2 words; or low when nonempty
// [RULE3] half-full low from half plus two words
// [RULE4] paf low from cap-m; ir high at capacity
// [RULE5] defaults 127 parallel, 1023 serial
// [RULE6] loading method latched only during master reset
// [RULE7] load select high at reset means serial
// [RULE8] parallel write steps through offset byte registers
// [RULE9] parallel read steps through offset byte registers
// [RULE10] byte pointers wrap back to empty lsb
// [RULE11] serial shift one bit per edge, 32/34 total
// [RULE12] serial load covers every bit, no selection
// [RULE13] serial enable high blocks serial writes
// [RULE14] memory writes interleave; shifting resumes in place
// [RULE15] serial pause keeps bit position
// [RULE16] partial flags held invalid, valid two edges later
// [RULE17] no serial readback path exists
// [RULE18] parallel readback allowed in either method
// [RULE19] offset logic ignores the timing mode
// [RULE20] load select high routes strobes to memory
// [RULE21] output ready falls after first write
module ffo_device #(
    parameter bit LARGE = 1'b0,
    parameter int DEPTH = ffo_pkg::FIFO_DEPTH
) (
    input wire logic i_clock,
    input wire logic i_resetn,
    ffo_if.device bus,
    input wire logic [ffo_pkg::CNT_W-1:0] i_stored_count,
    input wire logic i_first_word_fall_through_mode,
    output logic o_mem_valid,
    input wire logic i_mem_ready,
    output logic [ffo_pkg::DATA_W-1:0] o_mem_data,
    input wire logic i_mem_read,
    output logic o_serial_method,
    output logic o_flags_valid
);
    import ffo_pkg::*;

    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_RUN = 2'b01,
        ST_SETTLE = 2'b10
    } ffo_state_t;

    logic [OFS_W-1:0] empty_ofs_reg, empty_ofs_next, full_ofs_reg, full_ofs_next;
    logic serial_reg, serial_next;
    logic [2:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
    logic [5:0] sptr_reg, sptr_next;
    logic [1:0] settle_reg, settle_next;
    ffo_state_t state_reg, state_next;
    logic [DATA_W-1:0] q_reg, q_next;
    logic [2:0] nregs;
    logic [5:0] nbits;
    logic par_wr, par_rd, ser_wr, mem_wr, mem_rd, fifo_in_ready;
    logic [CNT_W-1:0] cap, half;

    // which offset register and byte a parallel pointer addresses
    function automatic logic sel_full(input logic [2:0] p, input logic [2:0] n);
        sel_full = (p >= (n >> 1));
    endfunction
    function automatic logic [1:0] sel_byte(input logic [2:0] p, input logic [2:0] n);
        logic [2:0] b;
        b = sel_full(p, n) ? p - (n >> 1) : p;
        sel_byte = b[1:0];
    endfunction

    assign nregs = LARGE ? PAR_REGS_LARGE : PAR_REGS_SMALL;
    assign nbits = LARGE ? SER_BITS_LARGE : SER_BITS_SMALL;
    assign cap = LARGE ? CAP_LARGE : CAP_SMALL;
    assign half = LARGE ? HALF_LARGE : HALF_SMALL;

    // strobe decode; the timing mode never enters here [RULE19]
    assign par_wr = !bus.offset_load_select_n && !bus.write_strobe_n
        && bus.read_strobe_n && bus.serial_shift_enable_low; // [RULE8]
    assign par_rd = !bus.offset_load_select_n && bus.write_strobe_n
        && !bus.read_strobe_n && bus.serial_shift_enable_low; // [RULE9] [RULE18]
    assign ser_wr = serial_reg && !bus.offset_load_select_n && bus.write_strobe_n
        && bus.read_strobe_n && !bus.serial_shift_enable_low; // [RULE11] [RULE13] [RULE15]
    assign mem_wr = bus.offset_load_select_n && !bus.write_strobe_n
        && bus.master_reset_n; // [RULE20] [RULE14]
    assign mem_rd = bus.offset_load_select_n && !bus.read_strobe_n
        && bus.master_reset_n; // [RULE20]

    // offset registers, pointers and readback
    always_comb begin
        logic [1:0] by;
        logic [OFS_W-1:0] cur;
        logic [DATA_W-1:0] src;
        empty_ofs_next = empty_ofs_reg;
        full_ofs_next = full_ofs_reg;
        serial_next = serial_reg;
        wptr_next = wptr_reg;
        rptr_next = rptr_reg;
        sptr_next = sptr_reg;
        q_next = q_reg;
        by = '0;
        cur = '0;
        src = '0;
        if (!bus.master_reset_n) begin
            serial_next = bus.offset_load_select_n; // [RULE6] [RULE7]
            empty_ofs_next = serial_next ? OFS_DEF_SER : OFS_DEF_PAR; // [RULE5]
            full_ofs_next = empty_ofs_next;
            wptr_next = '0;
            rptr_next = '0;
            sptr_next = '0;
        end else begin
            if (par_wr) begin
                by = sel_byte(wptr_reg, nregs);
                cur = sel_full(wptr_reg, nregs) ? full_ofs_reg : empty_ofs_reg;
                case (by)
                    2'h0: cur[7:0] = bus.data_in_bus[7:0];
                    2'h1: cur[16:8] = bus.data_in_bus;
                    default: cur[16] = bus.data_in_bus[0];
                endcase
                if (!LARGE && by == 2'h1) begin
                    cur[16] = 1'b0;
                end
                if (LARGE && by == 2'h1) begin
                    cur[15:8] = bus.data_in_bus[7:0];
                    cur[16] = sel_full(wptr_reg, nregs) ? full_ofs_reg[16] : empty_ofs_reg[16];
                end
                if (sel_full(wptr_reg, nregs)) begin
                    full_ofs_next = cur;
                end else begin
                    empty_ofs_next = cur;
                end
                wptr_next = (wptr_reg == nregs - 1'b1) ? '0 : wptr_reg + 1'b1; // [RULE10]
            end
            if (par_rd) begin
                src = '0;
                cur = sel_full(rptr_reg, nregs) ? full_ofs_reg : empty_ofs_reg;
                by = sel_byte(rptr_reg, nregs);
                case (by)
                    2'h0: src = {1'b0, cur[7:0]};
                    2'h1: src = LARGE ? {1'b0, cur[15:8]} : cur[16:8];
                    default: src = {8'h00, cur[16]};
                endcase
                q_next = src; // readback only on the parallel path [RULE17]
                rptr_next = (rptr_reg == nregs - 1'b1) ? '0 : rptr_reg + 1'b1; // [RULE10]
            end
            if (ser_wr) begin
                // every bit position is walked in turn [RULE12]
                if (sptr_reg < 6'(OFS_W) - (LARGE ? 6'h0 : 6'h1)) begin
                    empty_ofs_next[sptr_reg[4:0]] = bus.serial_in;
                end else begin
                    full_ofs_next[5'(sptr_reg - (nbits >> 1))] = bus.serial_in;
                end
                sptr_next = (sptr_reg == nbits - 1'b1) ? '0 : sptr_reg + 1'b1; // [RULE15]
            end
            // a memory word reaches the output only on a memory read strobe [RULE20]
            if (mem_rd && i_mem_read && o_mem_valid) begin
                q_next = o_mem_data;
            end
        end
    end

    // flag validity: invalid while loading, settles two edges after [RULE16]
    always_comb begin
        state_next = state_reg;
        settle_next = settle_reg;
        case (state_reg)
            ST_RESET: state_next = bus.master_reset_n ? ST_RUN : ST_RESET;
            ST_RUN: begin
                if (par_wr || ser_wr) begin
                    state_next = ST_SETTLE;
                    settle_next = '0;
                end
            end
            ST_SETTLE: begin
                if (par_wr || ser_wr) begin
                    settle_next = '0;
                end else if ((wptr_reg == '0) && (sptr_reg == '0)) begin
                    settle_next = settle_reg + 1'b1;
                    if (settle_reg + 1'b1 == FLAG_SETTLE) begin
                        state_next = ST_RUN;
                    end
                end
            end
            default: state_next = ST_RESET;
        endcase
        if (!bus.master_reset_n) begin
            state_next = ST_RESET;
            settle_next = '0;
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            empty_ofs_reg <= OFS_DEF_PAR;
            full_ofs_reg <= OFS_DEF_PAR;
            serial_reg <= 1'b0;
            wptr_reg <= '0;
            rptr_reg <= '0;
            sptr_reg <= '0;
            q_reg <= '0;
            settle_reg <= '0;
            state_reg <= ST_RESET;
        end else begin
            empty_ofs_reg <= empty_ofs_next;
            full_ofs_reg <= full_ofs_next;
            serial_reg <= serial_next;
            wptr_reg <= wptr_next;
            rptr_reg <= rptr_next;
            sptr_reg <= sptr_next;
            q_reg <= q_next;
            settle_reg <= settle_next;
            state_reg <= state_next;
        end
    end

    // flag decode from the stored count in fall-through mode (low = asserted)
    always_comb begin
        logic [CNT_W-1:0] c;
        c = i_stored_count;
        bus.output_ready_flag_n = (c == '0); // [RULE1] [RULE21]
        bus.almost_empty_flag_n = (c >= CNT_W'(empty_ofs_reg) + 18'h00002); // [RULE2]
        bus.half_full_flag_n = !(c >= half); // [RULE3]
        bus.almost_full_flag_n = !(c >= cap - CNT_W'(full_ofs_reg)); // [RULE4]
        bus.input_ready_flag_n = (c >= cap) || !fifo_in_ready; // [RULE4]
    end

    assign bus.data_out_bus = q_reg;
    assign o_serial_method = serial_reg;
    assign o_flags_valid = (state_reg == ST_RUN);

    // words written to memory pass through a small buffer toward the core
    ffo_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .i_clock(i_clock),
        .i_resetn(i_resetn),
        .i_in_valid(mem_wr),
        .o_in_ready(fifo_in_ready),
        .i_in_data(bus.data_in_bus),
        .o_out_valid(o_mem_valid),
        .i_out_ready(i_mem_ready),
        .o_out_data(o_mem_data)
    );
endmodule

// ===== verilog/ffo_pkg.sv
package ffo_pkg;
    // stored count width covers the larger variant plus output register
    localparam int CNT_W = 18;
    localparam int DATA_W = 9;
    localparam int OFS_W = 17;
    // capacity in fall-through mode, memory plus output register
    localparam logic [CNT_W-1:0] CAP_SMALL = 18'h10001;
    localparam logic [CNT_W-1:0] CAP_LARGE = 18'h20001;
    // half-full threshold in fall-through mode
    localparam logic [CNT_W-1:0] HALF_SMALL = 18'h08002;
    localparam logic [CNT_W-1:0] HALF_LARGE = 18'h10002;
    // default offsets chosen by the load select level at master reset
    localparam logic [OFS_W-1:0] OFS_DEF_PAR = 17'h0007f;
    localparam logic [OFS_W-1:0] OFS_DEF_SER = 17'h003ff;
    // serial bit totals and parallel byte register totals
    localparam logic [5:0] SER_BITS_SMALL = 6'h20;
    localparam logic [5:0] SER_BITS_LARGE = 6'h22;
    localparam logic [2:0] PAR_REGS_SMALL = 3'h4;
    localparam logic [2:0] PAR_REGS_LARGE = 3'h6;
    // partial flags settle this many edges after the last offset bit
    localparam logic [1:0] FLAG_SETTLE = 2'h2;
    localparam int FIFO_DEPTH = 4;
endpackage

// ===== verilog/ffo_if.sv
`timescale 1ns/100ps
interface ffo_if;
    logic offset_load_select_n;
    logic write_strobe_n;
    logic read_strobe_n;
    logic serial_shift_enable_low;
    logic serial_in;
    logic master_reset_n;
    logic [ffo_pkg::DATA_W-1:0] data_in_bus;
    logic [ffo_pkg::DATA_W-1:0] data_out_bus;
    logic input_ready_flag_n;
    logic almost_full_flag_n;
    logic half_full_flag_n;
    logic almost_empty_flag_n;
    logic output_ready_flag_n;
    modport device (
        input offset_load_select_n, write_strobe_n, read_strobe_n,
        input serial_shift_enable_low, serial_in, master_reset_n, data_in_bus,
        output data_out_bus, input_ready_flag_n, almost_full_flag_n,
        output half_full_flag_n, almost_empty_flag_n, output_ready_flag_n
    );
    modport host (
        output offset_load_select_n, write_strobe_n, read_strobe_n,
        output serial_shift_enable_low, serial_in, master_reset_n, data_in_bus,
        input data_out_bus, input_ready_flag_n, almost_full_flag_n,
        input half_full_flag_n, almost_empty_flag_n, output_ready_flag_n
    );
endinterface

// ===== verilog/ffo_fifo.sv
`timescale 1ns/100ps
module ffo_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic push, pop;

    // flags come straight from the count so full and empty never lie
    assign o_in_ready = (cnt_reg != (AW+1)'(DEPTH));
    assign o_out_valid = (cnt_reg != '0);
    assign o_out_data = mem_reg[rd_reg];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    // pointer and count updates, wrapping at the depth
    always_comb begin
        wr_next = wr_reg;
        rd_next = rd_reg;
        cnt_next = cnt_reg;
        if (push) begin
            wr_next = (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
        end
        if (pop) begin
            rd_next = (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
        end
        if (push && !pop) begin
            cnt_next = cnt_reg + 1'b1;
        end else if (pop && !push) begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            cnt_reg <= cnt_next;
        end
    end

    // storage has no reset; contents are only read when counted valid
    always_ff @(posedge i_clock) begin
        if (push) begin
            mem_reg[wr_reg] <= i_in_data;
        end
    end
endmodule

// ===== verilog/ffo_host.sv
`timescale 1ns/100ps
module ffo_host (
    input wire logic i_clock,
    input wire logic i_resetn,
    ffo_if.host bus,
    input wire logic i_master_reset,
    input wire logic i_serial_select,
    input wire logic [1:0] i_op,
    input wire logic i_serial_bit,
    input wire logic [ffo_pkg::DATA_W-1:0] i_data,
    output logic [ffo_pkg::DATA_W-1:0] o_read_data,
    output logic o_read_valid,
    output logic o_almost_full,
    output logic o_almost_empty,
    output logic o_half_full,
    output logic o_full,
    output logic o_empty
);
    import ffo_pkg::*;
    // op codes: 0 idle, 1 offset write or memory write, 2 offset read or memory read, 3 serial shift
    logic [1:0] op;
    logic rd_pend_reg, rd_pend_next;
    logic [DATA_W-1:0] rd_data_reg, rd_data_next;

    assign op = i_master_reset ? 2'h0 : i_op;

    // pin levels for each op; load select carries the method strap in reset [RULE7]
    always_comb begin
        bus.master_reset_n = !i_master_reset;
        // outside master reset the same level routes both strobes to memory
        bus.offset_load_select_n = i_serial_select;
        bus.write_strobe_n = !(op == 2'h1); // [RULE8]
        bus.read_strobe_n = !(op == 2'h2); // [RULE9]
        bus.serial_shift_enable_low = !(op == 2'h3); // [RULE11]
        bus.serial_in = i_serial_bit;
        bus.data_in_bus = i_data;
    end

    // offset readback appears on the bus one edge after the strobe
    always_comb begin
        rd_pend_next = (op == 2'h2);
        rd_data_next = rd_pend_reg ? bus.data_out_bus : rd_data_reg;
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            rd_pend_reg <= 1'b0;
            rd_data_reg <= '0;
            o_read_valid <= 1'b0;
        end else begin
            rd_pend_reg <= rd_pend_next;
            rd_data_reg <= rd_data_next;
            o_read_valid <= rd_pend_reg;
        end
    end

    assign o_read_data = rd_data_reg;
    assign o_almost_full = !bus.almost_full_flag_n;
    assign o_almost_empty = !bus.almost_empty_flag_n;
    assign o_half_full = !bus.half_full_flag_n;
    assign o_full = bus.input_ready_flag_n;
    assign o_empty = bus.output_ready_flag_n;
endmodule

// ===== verification/ffo_assertions.sv
`timescale 1ns/100ps
module ffo_assertions (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic offset_load_select_n,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic serial_shift_enable_low,
    input wire logic master_reset_n,
    input wire logic [ffo_pkg::DATA_W-1:0] data_out_bus,
    input wire logic input_ready_flag_n,
    input wire logic almost_full_flag_n,
    input wire logic half_full_flag_n,
    input wire logic output_ready_flag_n
);
    import ffo_pkg::*;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);
    // any read strobe, memory or offset, may move the output bus
    logic any_read;
    assign any_read = !read_strobe_n;
    sequence s_offset_write;
        !offset_load_select_n && !write_strobe_n;
    endsequence
    sequence s_offset_read;
        !offset_load_select_n && !read_strobe_n;
    endsequence
    // flag combinations that hold whatever the offsets are
    a_empty_flags: assert property (output_ready_flag_n |-> !input_ready_flag_n && half_full_flag_n)
        else $error("empty flag set wrong");
    a_full_flags: assert property (input_ready_flag_n |-> !almost_full_flag_n && !half_full_flag_n)
        else $error("full flag set wrong");
    a_half_not_empty: assert property (!half_full_flag_n |-> !output_ready_flag_n)
        else $error("half full while empty");
    // strobe decode: one offset access kind at a time
    a_write_no_read: assert property (s_offset_write |-> read_strobe_n && serial_shift_enable_low)
        else $error("offset write mixed with other strobes");
    a_read_no_write: assert property (s_offset_read |-> write_strobe_n && serial_shift_enable_low)
        else $error("offset read mixed with other strobes");
    a_shift_strobes: assert property (!offset_load_select_n && !serial_shift_enable_low
        |-> write_strobe_n && read_strobe_n)
        else $error("serial shift with strobe low");
    // output bus is overwritten only by a read
    a_data_needs_read: assert property ($changed(data_out_bus) |-> $past(any_read))
        else $error("data out changed without read");
    a_mreset_idle: assert property (!master_reset_n
        |-> write_strobe_n && read_strobe_n && serial_shift_enable_low)
        else $error("access during master reset");
    c_offset_read: cover property (s_offset_read);
endmodule

// ===== verification/test_fifo_flag_offset_programming.sv
`timescale 1ns/100ps
module test_fifo_flag_offset_programming;
    import ffo_pkg::*;
    logic i_clock = 1'b0;
    logic i_resetn = 1'b0;
    logic mr = 1'b0;
    logic sel = 1'b0;
    logic [1:0] op = 2'h0;
    logic sbit = 1'b0;
    logic [DATA_W-1:0] din = '0;
    logic [CNT_W-1:0] cnt = '0;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
    logic smethod;
    logic fvalid;
    logic mrdy = 1'b0;
    logic mvalid;
    logic [DATA_W-1:0] mdata;
    logic first_word_fall_through_mode = 1'b1;
    logic h_af;
    logic h_ae;
    logic h_hf;
    logic h_full;
    logic h_empty;
    int fails = 0;
    int cmp_count = 0;
    int cycles = 0;
    ffo_if u_ffo_if ();
    ffo_host u_ffo_host (.i_clock(i_clock), .i_resetn(i_resetn), .bus(u_ffo_if),
        .i_master_reset(mr), .i_serial_select(sel), .i_op(op), .i_serial_bit(sbit),
        .i_data(din), .o_read_data(rdata), .o_read_valid(rvalid), .o_almost_full(h_af),
        .o_almost_empty(h_ae), .o_half_full(h_hf), .o_full(h_full), .o_empty(h_empty));
    ffo_device u_ffo_device (.i_clock(i_clock), .i_resetn(i_resetn), .bus(u_ffo_if),
        .i_stored_count(cnt), .i_first_word_fall_through_mode(first_word_fall_through_mode), .o_mem_valid(mvalid),
        .i_mem_ready(mrdy), .o_mem_data(mdata), .i_mem_read(1'b1), .o_serial_method(smethod),
        .o_flags_valid(fvalid));
    ffo_assertions u_ffo_assertions (.i_clock(i_clock), .i_resetn(i_resetn),
        .offset_load_select_n(u_ffo_if.offset_load_select_n),
        .write_strobe_n(u_ffo_if.write_strobe_n), .read_strobe_n(u_ffo_if.read_strobe_n),
        .serial_shift_enable_low(u_ffo_if.serial_shift_enable_low),
        .master_reset_n(u_ffo_if.master_reset_n), .data_out_bus(u_ffo_if.data_out_bus),
        .input_ready_flag_n(u_ffo_if.input_ready_flag_n),
        .almost_full_flag_n(u_ffo_if.almost_full_flag_n),
        .half_full_flag_n(u_ffo_if.half_full_flag_n),
        .output_ready_flag_n(u_ffo_if.output_ready_flag_n));
    // 40 ns period
    always #20 i_clock = ~i_clock;
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ceiling well above the hundred or so cycles the sequence needs
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            end_of_test();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #2;
    endtask
    task automatic check(input string what, input logic [CNT_W-1:0] exp,
            input logic [CNT_W-1:0] got);
        cmp_count++;
        if (exp !== got) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one request per call; caller returns op to idle itself
    task automatic do_op(input logic [1:0] code, input logic [DATA_W-1:0] d, input logic b);
        op = code;
        din = d;
        sbit = b;
        tick(1);
    endtask
    task automatic mreset(input logic s);
        sel = s;
        mr = 1'b1;
        tick(2);
        mr = 1'b0;
        sel = 1'b0;
        tick(1);
    endtask
    // offset read; answer is a one-cycle pulse, so look at every edge
    task automatic rd(input logic [DATA_W-1:0] exp);
        int k;
        do_op(2'h2, '0, 1'b0);
        op = 2'h0;
        for (k = 0; k < 6 && rvalid !== 1'b1; k++) begin
            tick(1);
        end
        check("read valid", 18'h1, {17'h0, rvalid});
        check("offset readback", {9'h0, exp}, {9'h0, rdata});
    endtask
    // flag table at its boundary counts for offsets n and m
    task automatic chk_flags(input logic [CNT_W-1:0] n, input logic [CNT_W-1:0] m);
        logic [CNT_W-1:0] c;
        logic [CNT_W-1:0] pts [9];
        logic [4:0] e;
        pts = '{18'h0, 18'h1, n + 18'h1, n + 18'h2, HALF_SMALL - 18'h1, HALF_SMALL,
            CAP_SMALL - m - 18'h1, CAP_SMALL - m, CAP_SMALL};
        foreach (pts[i]) begin
            c = pts[i];
            cnt = c;
            #1;
            e = {c >= CAP_SMALL, c < CAP_SMALL - m, c < HALF_SMALL, c >= n + 18'h2, c == 18'h0};
            check("flags", {13'h0, e}, {13'h0, u_ffo_if.input_ready_flag_n,
                u_ffo_if.almost_full_flag_n, u_ffo_if.half_full_flag_n,
                u_ffo_if.almost_empty_flag_n, u_ffo_if.output_ready_flag_n});
            check("host flags", {13'h0, e[4], ~e[3:1], e[0]}, {13'h0, h_full, h_af, h_hf, h_ae, h_empty});
        end
        cnt = '0;
    endtask
    logic [15:0] sn;
    logic [15:0] sm;
    initial begin
        tick(8);
        i_resetn = 1'b1;
        tick(1);
        // parallel method with its defaults
        mreset(1'b0);
        check("method", 18'h0, {17'h0, smethod});
        chk_flags(18'h7f, 18'h7f);
        // serial shifts must be refused in parallel method
        for (int i = 0; i < 32; i++) do_op(2'h3, '0, 1'b1);
        op = 2'h0;
        sel = 1'b1;
        tick(3);
        check("method kept", 18'h0, {17'h0, smethod});
        // load select high routes both strobes to memory
        do_op(2'h1, 9'h1a5, 1'b0);
        op = 2'h0;
        check("mem valid", 18'h1, {17'h0, mvalid});
        check("mem data", 18'h1a5, {9'h0, mdata});
        rd(9'h1a5);
        mrdy = 1'b1;
        tick(2);
        check("mem drained", 18'h0, {17'h0, mvalid});
        sel = 1'b0;
        rd(9'h07f);
        rd(9'h000);
        rd(9'h07f);
        rd(9'h000);
        // parallel load: empty offset 5, full offset 10
        do_op(2'h1, 9'h005, 1'b0);
        check("flags valid low", 18'h0, {17'h0, fvalid});
        do_op(2'h1, 9'h000, 1'b0);
        do_op(2'h1, 9'h00a, 1'b0);
        do_op(2'h1, 9'h000, 1'b0);
        op = 2'h0;
        tick(4);
        check("flags valid", 18'h1, {17'h0, fvalid});
        chk_flags(18'h5, 18'ha);
        rd(9'h005);
        rd(9'h000);
        rd(9'h00a);
        rd(9'h000);
        rd(9'h005);
        // serial method, defaults, then a full shift with a pause
        mreset(1'b1);
        check("method serial", 18'h1, {17'h0, smethod});
        chk_flags(18'h3ff, 18'h3ff);
        sn = 16'h0014;
        sm = 16'h001e;
        for (int i = 0; i < 32; i++) begin
            do_op(2'h3, '0, (i < 16) ? sn[i] : sm[i-16]);
            if (i == 10) begin
                op = 2'h0;
                tick(3);
                check("flags invalid", 18'h0, {17'h0, fvalid});
                // a memory write in the pause must not disturb the shift position
                sel = 1'b1;
                do_op(2'h1, 9'h055, 1'b0);
                op = 2'h0;
                sel = 1'b0;
                check("mem word serial", {8'h0, 1'b1, 9'h055}, {8'h0, mvalid, mdata});
            end
        end
        op = 2'h0;
        tick(4);
        check("flags valid serial", 18'h1, {17'h0, fvalid});
        chk_flags(18'h14, 18'h1e);
        // readback only through parallel reads, also in serial method
        first_word_fall_through_mode = 1'b0;
        rd(9'h014);
        rd(9'h000);
        rd(9'h01e);
        rd(9'h000);
        end_of_test();
    end
endmodule
